// ===== core/routing_defines.svh
// Offsets, field positions, reset values and fixed masks of the routing block
`ifndef ROUTING_DEFINES_SVH
`define ROUTING_DEFINES_SVH

// Register byte addresses
`define OFF_PORT_P_DATA        12'h258
`define OFF_PORT_P_DIR         12'h25c
`define OFF_ROUTING_TWO        12'h260
`define OFF_LINK_CTRL          12'h264

// Reset values
`define RST_PORT_P_DATA        8'h00
`define RST_PORT_P_DIR         8'h00
`define RST_ROUTING_TWO        8'h00
`define RST_LINK_CTRL          8'h00

// Field positions of the routing register
`define RT_CAPTURE_BIT         7
`define RT_SPI_BIT             5
`define RT_SERIAL_ONE_BIT      4
`define RT_LIN_MSB             3
`define RT_LIN_LSB             0
`define RT_WRITE_MASK          8'hbf

// Field positions of the link control register
`define LC_DIRECT_DRIVE_BIT    0
`define LC_PHY_ENABLE_BIT      1
`define LC_WRITE_MASK          8'h03

// Port P data bits 7:6 always read zero
`define PORT_P_DATA_MASK       8'h3f
// Pins whose PWM may be moved to port S
`define PWM_PORT_S_PINS        6'h30
// Pins whose PWM yields to a routed driver function
`define PWM_DRIVER_PINS        6'h3a

// AXI4-Lite responses
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// ===== core/routing_pkg.sv
// Types shared by the peripheral signal routing block
package routing_pkg;

  typedef enum logic [3:0] {
    LIN_INTERNAL = 4'h0,
    LIN_DIRECT   = 4'h1,
    LIN_PROBE    = 4'hc,
    LIN_CONFORM  = 4'he
  } lin_route_mode_t;

endpackage : routing_pkg

// ===== core/pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage_one_reg;
  logic [WIDTH-1:0] stage_one_next;
  logic [WIDTH-1:0] stage_two_next;

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync: WIDTH must be at least 1");
  end

  always_comb
  begin
    stage_one_next = pin_in;
    stage_two_next = stage_one_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage_one_reg <= '0;
      pin_sync_out  <= '0;
    end
    else
    begin
      stage_one_reg <= stage_one_next;
      pin_sync_out  <= stage_two_next;
    end
  end

endmodule : pin_sync

// ===== core/peripheral_signal_routing.sv
// Peripheral-to-pin routing with port P data register, AXI4-Lite slave
`timescale 1ns/1ps
`include "routing_defines.svh"
module peripheral_signal_routing #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Chip state
  input  wire logic              special_mode,
  input  wire logic              serial_zero_enable,
  input  wire logic              serial_one_enable,
  // Serial interface zero and transceiver
  input  wire logic              serial_zero_tx,
  output logic                   serial_zero_rx,
  output logic                   transceiver_tx_in,
  input  wire logic              transceiver_rx_out,
  // Serial interface one
  input  wire logic              serial_one_tx,
  output logic                   serial_one_rx,
  // SPI
  input  wire logic              spi_ss_out,
  input  wire logic              spi_ss_oe,
  input  wire logic              spi_sck_out,
  input  wire logic              spi_sck_oe,
  output logic                   spi_ss_in,
  output logic                   spi_sck_in,
  // Timer unit
  output logic                   timer_capture_three,
  // Timer port pins
  input  wire logic [3:0]        timer_pin_in,
  output logic      [3:0]        timer_pin_out,
  output logic      [3:0]        timer_pin_oe,
  // Port S pins
  input  wire logic [5:0]        s_pin_in,
  output logic      [5:0]        s_pin_out,
  output logic      [5:0]        s_pin_oe,
  // PWM and driver state for port P
  input  wire logic [5:0]        pwm_out,
  input  wire logic [5:0]        pwm_channel_enable,
  input  wire logic [5:0]        pwm_to_port_s,
  input  wire logic [5:0]        driver_uses_pin,
  // Port P pins
  input  wire logic [5:0]        p_pin_in,
  output logic      [5:0]        p_pin_out,
  output logic      [5:0]        p_pin_oe
);

  initial
  begin
    if (ADDR_W < 10 || ADDR_W > 32)
      $error("peripheral_signal_routing: ADDR_W must be 10..32");
  end

  // Literals cannot be bit-selected, so the masks get names
  localparam logic [5:0] PWM_S_MASK   = `PWM_PORT_S_PINS;
  localparam logic [5:0] PWM_DRV_MASK = `PWM_DRIVER_PINS;

  // Register file
  logic [7:0]        port_p_pin_data_reg, port_p_pin_data_next;
  logic [7:0]        port_p_dir_reg, port_p_dir_next;
  logic [7:0]        peripheral_routing_two_reg, peripheral_routing_two_next;
  logic [7:0]        link_ctrl_reg, link_ctrl_next;
  logic              route_lock_reg, route_lock_next;
  // Bus state
  logic              aw_have_reg, aw_have_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic              w_have_reg, w_have_next;
  logic [7:0]        w_data_reg, w_data_next;
  logic              w_lane_reg, w_lane_next;
  logic              awready_next, wready_next, bvalid_next;
  logic              arready_next, rvalid_next;
  logic [1:0]        bresp_next, rresp_next;
  logic [31:0]       rdata_next;
  // Pin and peripheral outputs
  logic              serial_zero_rx_next, transceiver_tx_in_next;
  logic              serial_one_rx_next, spi_ss_in_next, spi_sck_in_next;
  logic              timer_capture_three_next;
  logic [3:0]        timer_pin_out_next, timer_pin_oe_next;
  logic [5:0]        s_pin_out_next, s_pin_oe_next;
  logic [5:0]        p_pin_out_next, p_pin_oe_next;

  logic [5:0]        p_pin_sync;
  logic [5:0]        pwm_avail;
  logic [5:0]        p_read;
  routing_pkg::lin_route_mode_t lin_mode;
  logic              phy_on;
  logic              aw_fire, w_fire, wr_fire, ar_fire;
  logic [ADDR_W-1:0] ar_word, aw_word;

  pin_sync #(
    .WIDTH (6)
  ) u_port_p_sync (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .pin_in       (p_pin_in),
    .pin_sync_out (p_pin_sync)
  );

  assign lin_mode = routing_pkg::lin_route_mode_t'(
                      peripheral_routing_two_reg[`RT_LIN_MSB:`RT_LIN_LSB]);
  assign phy_on   = link_ctrl_reg[`LC_PHY_ENABLE_BIT];

  // Register and bus next-state logic
  always_comb
  begin
    aw_fire  = s_axi_awvalid && s_axi_awready;
    w_fire   = s_axi_wvalid && s_axi_wready;
    ar_fire  = s_axi_arvalid && s_axi_arready;
    wr_fire  = aw_have_reg && w_have_reg && !s_axi_bvalid;
    aw_word  = {aw_addr_reg[ADDR_W-1:2], 2'b00};
    ar_word  = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    for (int i = 0; i < 6; i++)
      p_read[i] = port_p_dir_reg[i] ? port_p_pin_data_reg[i]
                                    : p_pin_sync[i];

    port_p_pin_data_next        = port_p_pin_data_reg;
    port_p_dir_next             = port_p_dir_reg;
    peripheral_routing_two_next = peripheral_routing_two_reg;
    link_ctrl_next              = link_ctrl_reg;
    route_lock_next             = route_lock_reg;
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_lane_next  = w_lane_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    rvalid_next  = s_axi_rvalid;
    rresp_next   = s_axi_rresp;
    rdata_next   = s_axi_rdata;

    if (aw_fire)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (w_fire)
    begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;

    if (wr_fire)
    begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RESP_OKAY;
      case (aw_word)
        ADDR_W'(`OFF_PORT_P_DATA):
          if (w_lane_reg)
            port_p_pin_data_next = w_data_reg & `PORT_P_DATA_MASK;
        ADDR_W'(`OFF_PORT_P_DIR):
          if (w_lane_reg)
            port_p_dir_next = w_data_reg & `PORT_P_DATA_MASK;
        ADDR_W'(`OFF_ROUTING_TWO):
          // Locked writes finish with OKAY but change nothing
          if (w_lane_reg && (special_mode || !route_lock_reg))
          begin
            peripheral_routing_two_next = w_data_reg & `RT_WRITE_MASK;
            if (!special_mode)
              route_lock_next = 1'b1;
          end
        ADDR_W'(`OFF_LINK_CTRL):
          if (w_lane_reg)
            link_ctrl_next = w_data_reg & `LC_WRITE_MASK;
        default:
          bresp_next = `RESP_SLVERR;
      endcase
    end

    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (ar_fire)
    begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      case (ar_word)
        ADDR_W'(`OFF_PORT_P_DATA):
          rdata_next[7:0] = {2'b00, p_read};
        ADDR_W'(`OFF_PORT_P_DIR):
          rdata_next[7:0] = port_p_dir_reg;
        ADDR_W'(`OFF_ROUTING_TWO):
          rdata_next[7:0] = peripheral_routing_two_reg;
        ADDR_W'(`OFF_LINK_CTRL):
          rdata_next[7:0] = link_ctrl_reg;
        default:
          rresp_next = `RESP_SLVERR;
      endcase
    end

    // Ready flags are registered from the next held state, so they match the held state in the same cycle
    awready_next = !aw_have_next;
    wready_next  = !w_have_next;
    arready_next = !rvalid_next;
  end

  // Pin routing next-state logic
  always_comb
  begin
    timer_pin_out_next = 4'h0;
    timer_pin_oe_next  = 4'h0;
    s_pin_out_next     = 6'h00;
    s_pin_oe_next      = 6'h00;
    serial_zero_rx_next    = transceiver_rx_out;
    transceiver_tx_in_next = serial_zero_tx;

    case (lin_mode)
      routing_pkg::LIN_INTERNAL:
        transceiver_tx_in_next = serial_zero_tx;
      routing_pkg::LIN_DIRECT:
        // Off transceiver keeps the serial line so no stale bit leaks
        transceiver_tx_in_next = phy_on ?
          link_ctrl_reg[`LC_DIRECT_DRIVE_BIT] : serial_zero_tx;
      routing_pkg::LIN_PROBE:
      begin
        timer_pin_out_next[3] = serial_zero_tx;
        timer_pin_oe_next[3]  = serial_zero_enable;
        timer_pin_out_next[2] = transceiver_rx_out;
        timer_pin_oe_next[2]  = phy_on;
      end
      routing_pkg::LIN_CONFORM:
      begin
        transceiver_tx_in_next = timer_pin_in[3];
        serial_zero_rx_next    = timer_pin_in[0];
        timer_pin_out_next[1]  = serial_zero_tx;
        timer_pin_oe_next[1]   = serial_zero_enable;
        timer_pin_out_next[2]  = transceiver_rx_out;
        timer_pin_oe_next[2]   = phy_on;
      end
      default:
        transceiver_tx_in_next = serial_zero_tx;
    endcase

    // SPI yields timer pins already driven by the transceiver routes
    if (peripheral_routing_two_reg[`RT_SPI_BIT])
    begin
      spi_ss_in_next  = timer_pin_in[3];
      spi_sck_in_next = timer_pin_in[2];
      if (!timer_pin_oe_next[3])
      begin
        timer_pin_out_next[3] = spi_ss_out;
        timer_pin_oe_next[3]  = spi_ss_oe;
      end
      if (!timer_pin_oe_next[2])
      begin
        timer_pin_out_next[2] = spi_sck_out;
        timer_pin_oe_next[2]  = spi_sck_oe;
      end
    end
    else
    begin
      spi_ss_in_next   = s_pin_in[5];
      spi_sck_in_next  = s_pin_in[4];
      s_pin_out_next[5] = spi_ss_out;
      s_pin_oe_next[5]  = spi_ss_oe;
      s_pin_out_next[4] = spi_sck_out;
      s_pin_oe_next[4]  = spi_sck_oe;
    end

    if (peripheral_routing_two_reg[`RT_SERIAL_ONE_BIT])
    begin
      serial_one_rx_next = s_pin_in[2];
      s_pin_out_next[3]  = serial_one_tx;
      s_pin_oe_next[3]   = serial_one_enable;
    end
    else
    begin
      serial_one_rx_next = s_pin_in[0];
      s_pin_out_next[1]  = serial_one_tx;
      s_pin_oe_next[1]   = serial_one_enable;
    end

    timer_capture_three_next =
      peripheral_routing_two_reg[`RT_CAPTURE_BIT] ?
      transceiver_rx_out : timer_pin_in[3];

    for (int i = 0; i < 6; i++)
    begin
      pwm_avail[i] = pwm_channel_enable[i]
        && !(PWM_S_MASK[i] && pwm_to_port_s[i])
        && !(PWM_DRV_MASK[i] && driver_uses_pin[i]);
      p_pin_out_next[i] = pwm_avail[i] ? pwm_out[i] : port_p_pin_data_reg[i];
      p_pin_oe_next[i]  = pwm_avail[i] || port_p_dir_reg[i];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port_p_pin_data_reg        <= `RST_PORT_P_DATA;
      port_p_dir_reg             <= `RST_PORT_P_DIR;
      peripheral_routing_two_reg <= `RST_ROUTING_TWO;
      link_ctrl_reg              <= `RST_LINK_CTRL;
      route_lock_reg             <= 1'b0;
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      w_have_reg    <= 1'b0;
      w_data_reg    <= 8'h00;
      w_lane_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
      serial_zero_rx      <= 1'b0;
      transceiver_tx_in   <= 1'b0;
      serial_one_rx       <= 1'b0;
      spi_ss_in           <= 1'b0;
      spi_sck_in          <= 1'b0;
      timer_capture_three <= 1'b0;
      timer_pin_out <= 4'h0;
      timer_pin_oe  <= 4'h0;
      s_pin_out     <= 6'h00;
      s_pin_oe      <= 6'h00;
      p_pin_out     <= 6'h00;
      p_pin_oe      <= 6'h00;
    end
    else
    begin
      port_p_pin_data_reg        <= port_p_pin_data_next;
      port_p_dir_reg             <= port_p_dir_next;
      peripheral_routing_two_reg <= peripheral_routing_two_next;
      link_ctrl_reg              <= link_ctrl_next;
      route_lock_reg             <= route_lock_next;
      aw_have_reg   <= aw_have_next;
      aw_addr_reg   <= aw_addr_next;
      w_have_reg    <= w_have_next;
      w_data_reg    <= w_data_next;
      w_lane_reg    <= w_lane_next;
      s_axi_awready <= awready_next;
      s_axi_wready  <= wready_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rresp   <= rresp_next;
      s_axi_rdata   <= rdata_next;
      serial_zero_rx      <= serial_zero_rx_next;
      transceiver_tx_in   <= transceiver_tx_in_next;
      serial_one_rx       <= serial_one_rx_next;
      spi_ss_in           <= spi_ss_in_next;
      spi_sck_in          <= spi_sck_in_next;
      timer_capture_three <= timer_capture_three_next;
      timer_pin_out <= timer_pin_out_next;
      timer_pin_oe  <= timer_pin_oe_next;
      s_pin_out     <= s_pin_out_next;
      s_pin_oe      <= s_pin_oe_next;
      p_pin_out     <= p_pin_out_next;
      p_pin_oe      <= p_pin_oe_next;
    end
  end

endmodule : peripheral_signal_routing

// ===== dv/periph_model.sv
// Far-side model of serial, SPI and transceiver signal sources
`timescale 1ns/1ps
module periph_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Peripheral lines toward the router
  output logic      serial_zero_tx,
  output logic      serial_one_tx,
  output logic      transceiver_rx_out,
  output logic      spi_ss_out,
  output logic      spi_ss_oe,
  output logic      spi_sck_out,
  output logic      spi_sck_oe
);
  logic [15:0] lfsr_reg = 16'h00a5;

  // Lines follow an LFSR stepped every cycle so a stale route seldom matches by luck
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      lfsr_reg <= 16'h00a5;
    else
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end
  assign serial_zero_tx     = lfsr_reg[0];
  assign serial_one_tx      = lfsr_reg[3];
  assign transceiver_rx_out = lfsr_reg[6];
  assign spi_ss_out         = lfsr_reg[8];
  assign spi_ss_oe          = lfsr_reg[10];
  assign spi_sck_out        = lfsr_reg[12];
  assign spi_sck_oe         = lfsr_reg[14];
endmodule : periph_model

// ===== dv/routing_assertions.sv
// Port-level checker for the peripheral signal routing block
`timescale 1ns/1ps
`include "routing_defines.svh"
module routing_assertions (
  // Clock, reset, chip state
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        special_mode,
  input wire logic        serial_zero_enable,
  // Register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Routed signals
  input wire logic        serial_zero_tx,
  input wire logic        serial_zero_rx,
  input wire logic        transceiver_tx_in,
  input wire logic        transceiver_rx_out,
  input wire logic        serial_one_rx,
  input wire logic        spi_ss_in,
  input wire logic        spi_ss_oe,
  input wire logic        spi_sck_oe,
  input wire logic        timer_capture_three,
  input wire logic [3:0]  timer_pin_in,
  input wire logic [3:0]  timer_pin_oe,
  input wire logic [5:0]  s_pin_in,
  // Port P
  input wire logic [5:0]  pwm_out,
  input wire logic [5:0]  pwm_channel_enable,
  input wire logic [5:0]  pwm_to_port_s,
  input wire logic [5:0]  driver_uses_pin,
  input wire logic [5:0]  p_pin_out,
  input wire logic [5:0]  p_pin_oe
);
  logic [7:0]  rt_reg, lc_reg, wd_reg;
  logic [11:0] wa_reg;
  logic        ws_reg, lock_reg, bv_reg;
  logic [2:0]  quiet_reg;
  wire  [3:0]  md = rt_reg[3:0];
  // Checks pause around writes, while the shadow copy catches up
  wire         quiet = &quiet_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rt_reg <= 8'h00;
      lc_reg <= 8'h00;
      lock_reg <= 1'h0;
      bv_reg <= 1'h0;
      quiet_reg <= 3'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        wa_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_reg <= s_axi_wdata[7:0];
        ws_reg <= s_axi_wstrb[0];
      end
      bv_reg <= s_axi_bvalid;
      quiet_reg <= {quiet_reg[1:0], !s_axi_bvalid};
      if (s_axi_bvalid && !bv_reg && ws_reg)
      begin
        if (wa_reg == `OFF_ROUTING_TWO && (special_mode || !lock_reg))
        begin
          rt_reg <= wd_reg & `RT_WRITE_MASK;
          lock_reg <= lock_reg | !special_mode;
        end
        if (wa_reg == `OFF_LINK_CTRL)
          lc_reg <= wd_reg & `LC_WRITE_MASK;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response not two cycles after request");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  a_capture_route: assert property (
    quiet |-> timer_capture_three ==
    (rt_reg[7] ? $past(transceiver_rx_out) : $past(timer_pin_in[3])))
    else $error("capture channel source wrong");
  a_spi_route: assert property (
    quiet && md != 4'hc && md != 4'he |->
    spi_ss_in == (rt_reg[5] ? $past(timer_pin_in[3]) : $past(s_pin_in[5])))
    else $error("spi select source wrong");
  a_serial_one_route: assert property (
    quiet |-> serial_one_rx ==
    (rt_reg[4] ? $past(s_pin_in[2]) : $past(s_pin_in[0])))
    else $error("serial one receive source wrong");
  a_internal_link: assert property (
    quiet && md == 4'h0 |->
    transceiver_tx_in == $past(serial_zero_tx) &&
    serial_zero_rx == $past(transceiver_rx_out))
    else $error("internal link broken");
  a_direct_drive: assert property (
    quiet && md == 4'h1 |-> transceiver_tx_in ==
    (lc_reg[1] ? lc_reg[0] : $past(serial_zero_tx)))
    else $error("direct drive route wrong");
  // Probe pins left undriven fall back to the SPI
  a_probe_pins: assert property (
    quiet && md == 4'hc |->
    timer_pin_oe[3] == ($past(serial_zero_enable) ||
    rt_reg[5] && $past(spi_ss_oe)) &&
    timer_pin_oe[2] == (lc_reg[1] || rt_reg[5] && $past(spi_sck_oe)) &&
    transceiver_tx_in == $past(serial_zero_tx))
    else $error("probe route wrong");
  a_conform_pins: assert property (
    quiet && md == 4'he |->
    transceiver_tx_in == $past(timer_pin_in[3]) &&
    serial_zero_rx == $past(timer_pin_in[0]) &&
    timer_pin_oe[1] == $past(serial_zero_enable))
    else $error("conformance route wrong");
  a_pwm_pin: assert property (
    quiet && $past(pwm_channel_enable[5] && !pwm_to_port_s[5] &&
    !driver_uses_pin[5]) |-> p_pin_oe[5] && p_pin_out[5] == $past(pwm_out[5]))
    else $error("pwm not offered on free pin");
endmodule : routing_assertions

bind peripheral_signal_routing routing_assertions chk_inst (.*);

// ===== dv/tb_top.sv
// Self-checking bench for the peripheral signal routing block
`timescale 1ns/1ps
`include "routing_defines.svh"
module tb_top;
  logic mclk, rst_n, special_mode, serial_zero_enable, serial_one_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0] s_axi_wstrb, timer_pin_out, timer_pin_oe, t_ext;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, rnd_on;
  logic serial_zero_tx, serial_zero_rx, transceiver_tx_in, transceiver_rx_out;
  logic serial_one_tx, serial_one_rx, spi_ss_in, spi_sck_in;
  logic spi_ss_out, spi_ss_oe, spi_sck_out, spi_sck_oe, timer_capture_three;
  logic [5:0] s_pin_out, s_pin_oe, s_ext, p_pin_out, p_pin_oe, p_ext;
  logic [5:0] pwm_out, pwm_channel_enable, pwm_to_port_s, driver_uses_pin;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_total, checks_done;
  // Wire level from the router's enable; the external source drives where the router does not
  wire [3:0] timer_pin_in = timer_pin_oe & timer_pin_out | ~timer_pin_oe & t_ext;
  wire [5:0] s_pin_in = s_pin_oe & s_pin_out | ~s_pin_oe & s_ext;
  wire [5:0] p_pin_in = p_pin_oe & p_pin_out | ~p_pin_oe & p_ext;

  peripheral_signal_routing peripheral_signal_routing_inst (.*);
  periph_model periph_model_inst (.*);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  always @(posedge mclk)
  begin
    rnd <= xs(rnd);
    if (rnd_on)
      {t_ext, s_ext, pwm_out, serial_zero_enable, serial_one_enable} <=
        rnd[17:0];
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic note(input string n, input logic [33:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : note
  task automatic chk_read(input logic [33:0] e, g);
    note("read", e, g);
  endtask : chk_read
  task automatic chk_resp(input logic [1:0] e, g);
    note("bresp", {32'h0, e}, {32'h0, g});
  endtask : chk_resp
  task automatic chk_pin(input string n, input logic [5:0] e, g);
    note(n, {28'h0, e}, {28'h0, g});
  endtask : chk_pin

  always @(posedge mclk)
  begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk_read(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk_resp(bq.pop_front(), s_axi_bresp);
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'h0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic [1:0] r);
    rq.push_back({r, 24'h000000, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'h0;
    @(posedge mclk);
  endtask : rd

  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
  endtask : do_reset

  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end

  initial
  begin
    logic [7:0] tbl [6];
    logic [5:0] d;
    tbl = '{8'h80, 8'h31, 8'hac, 8'h9e, 8'h2e, 8'h10};
    rnd = 32'h0000004c;
    {rst_n, special_mode, serial_zero_enable, serial_one_enable} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, rnd_on} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {t_ext, s_ext, p_ext, pwm_out, pwm_channel_enable} = 28'h0;
    {pwm_to_port_s, driver_uses_pin} = 12'h0;
    do_reset();
    rd(`OFF_PORT_P_DATA, `RST_PORT_P_DATA, `RESP_OKAY);
    rd(`OFF_ROUTING_TWO, `RST_ROUTING_TWO, `RESP_OKAY);
    rd(12'h2f0, 8'h00, `RESP_SLVERR);
    wr(12'h2f0, 8'h55, `RESP_SLVERR);
    wr(`OFF_PORT_P_DIR, 8'h3f, `RESP_OKAY);
    wr(`OFF_PORT_P_DATA, 8'hff, `RESP_OKAY);
    rd(`OFF_PORT_P_DATA, 8'h3f, `RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      d = rnd[5:0];
      p_ext <= rnd[13:8];
      wr(`OFF_PORT_P_DIR, {2'h0, d}, `RESP_OKAY);
      repeat (4) @(posedge mclk);
      rd(`OFF_PORT_P_DATA, {2'h0, d | ~d & p_ext}, `RESP_OKAY);
    end
    wr(`OFF_ROUTING_TWO, 8'h01, `RESP_OKAY);
    wr(`OFF_ROUTING_TWO, 8'hb0, `RESP_OKAY);
    rd(`OFF_ROUTING_TWO, 8'h01, `RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFF_LINK_CTRL, i[7:0], `RESP_OKAY);
      repeat (2) @(posedge mclk);
      if (i >= 2)
        chk_pin("tx_in", {5'h0, i[0]}, {5'h0, transceiver_tx_in});
    end
    // A second reset must reopen the write-once register
    do_reset();
    wr(`OFF_ROUTING_TWO, 8'hff, `RESP_OKAY);
    wr(`OFF_ROUTING_TWO, 8'h00, `RESP_OKAY);
    rd(`OFF_ROUTING_TWO, 8'hbf, `RESP_OKAY);
    special_mode <= 1'h1;
    pwm_channel_enable <= 6'h3f;
    rnd_on <= 1'h1;
    foreach (tbl[i])
    begin
      wr(`OFF_ROUTING_TWO, tbl[i], `RESP_OKAY);
      wr(`OFF_LINK_CTRL, {6'h0, rnd[1:0]}, `RESP_OKAY);
      rd(`OFF_ROUTING_TWO, tbl[i], `RESP_OKAY);
      repeat (20) @(posedge mclk);
    end
    rnd_on <= 1'h0;
    wr(`OFF_ROUTING_TWO, 8'h0e, `RESP_OKAY);
    wr(`OFF_LINK_CTRL, 8'h00, `RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk_pin("timer_oe", {2'h0, serial_zero_enable, 1'h0}, timer_pin_oe);
    wr(`OFF_PORT_P_DIR, 8'h00, `RESP_OKAY);
    pwm_to_port_s <= 6'h30;
    repeat (2) @(posedge mclk);
    chk_pin("p_oe", 6'h0f, p_pin_oe);
    pwm_to_port_s <= 6'h00;
    driver_uses_pin <= 6'h0a;
    repeat (2) @(posedge mclk);
    chk_pin("p_oe", 6'h35, p_pin_oe);
    summarize();
  end
endmodule : tb_top
